// File: verilog/dima_arbiter.sv
/*
 * dima_arbiter: first-come first-served shared memory arbiter with buffer mirroring.
 * Assumes decoded requests arrive on clk_sys_in;
 * serial pins, field and supply detect are asynchronous.
 * Only start, stop and the address byte are decoded on the serial pins.
 */
`timescale 1ns/10ps

//  Contract
// RULE1: one interface owns memory, first come wins
// RULE2: both lock flags cleared at power-on
// RULE3: host lock: session reads, sector select allowed
// RULE4: contactless lock: host register commands still served
// RULE5: pass-through off means arbitration applies
// RULE6: address after start in idle/halt locks host
// RULE7: host lock: contactless memory access gets NAK
// RULE8: host clears lock, else watchdog clears it
// RULE9: contactless EEPROM access only without host lock
// RULE10: valid contactless access sets contactless lock
// RULE11: contactless lock cleared by reset/field/halt/done
// RULE12: reading final message page sets read-done
// RULE13: mirror enable maps buffer at base page
// RULE14: software never enables mirror with pass-through
// RULE15: base 01h puts buffer on pages 04h-13h
// RULE16: password protection covers mirrored pages when enabled
// RULE17: mirrored pages read-only when overlay is locked
// RULE18: mirror works only with main supply present
// RULE19: simultaneous requests resolved, contactless side wins
module dima_arbiter #(
    parameter int         WDT_LEN    = dima_pkg::WDT_CYCLES,
    parameter logic [6:0] SLAVE_ADDR = dima_pkg::SLAVE_ADDR_DEF
) (
    // clock and reset
    input  wire logic               clk_sys_in,
    input  wire logic               rst_in,
    // asynchronous pins
    input  wire logic               scl_in,
    input  wire logic               sda_in,
    input  wire logic               nfc_field_in,
    input  wire logic               vcc_present_in,
    // configuration
    input  wire logic               passthrough_enable_in,
    input  wire logic               mirror_enable_in,
    input  wire logic [7:0]         mirror_base_page_in,
    input  wire logic [7:0]         final_message_page_in,
    input  wire logic [7:0]         protect_start_page_in,
    input  wire logic               pwd_auth_enable_in,
    input  wire logic               buffer_password_protect_in,
    // contactless request
    input  wire logic               nfc_req_in,
    input  wire dima_pkg::dima_cmd_t nfc_cmd_in,
    input  wire logic [1:0]         nfc_sector_in,
    input  wire logic [7:0]         nfc_page_in,
    input  wire logic [7:0]         nfc_end_page_in,
    input  wire logic               nfc_idle_halt_in,
    input  wire logic               nfc_authenticated_in,
    input  wire logic               nfc_page_locked_ro_in,
    input  wire logic               nfc_done_in,
    // contactless answer
    output logic                    nfc_ack_out,
    output logic                    nfc_nak_out,
    output logic                    nfc_to_sram_out,
    output logic                    nfc_to_session_out,
    output logic [3:0]              nfc_sram_page_out,
    // host transactions
    input  wire logic               i2c_req_in,
    input  wire logic               i2c_reg_cmd_in,
    input  wire logic               i2c_reg_read_in,
    input  wire logic               i2c_unlock_in,
    input  wire logic               msg_done_clear_in,
    output logic                    i2c_ack_out,
    output logic                    i2c_nack_out,
    // session status
    output logic                    i2c_locked_out,
    output logic                    contactless_lock_flag_out,
    output logic                    message_read_done_out
);
    import dima_pkg::*;

    localparam int WDT_W = $clog2(WDT_LEN + 1);

    typedef enum {DIMA_SER_IDLE, DIMA_SER_ADDR, DIMA_SER_BUSY} dima_ser_t;

    logic [2:0]       scl_s_q;
    logic [2:0]       sda_s_q;
    logic [1:0]       field_s_q;
    logic [1:0]       vcc_s_q;
    dima_ser_t        ser_q;
    logic [3:0]       bit_cnt_q;
    logic [7:0]       shift_q;
    logic             addr_hit_q;
    logic             i2c_locked_q;
    logic             contactless_lock_flag_q;
    logic             msg_done_q;
    logic [WDT_W-1:0] wdt_q;
    logic             start_w;
    logic             stop_w;
    logic             scl_rise_w;
    logic             is_sess_w;
    logic             is_mir_w;
    logic             mem_cmd_w;
    logic             wr_cmd_w;
    logic             grant_w;
    logic             nak_w;
    logic             lock_nfc_w;
    logic             msg_set_w;
    logic             wdt_expire_w;
    logic [7:0]       mir_lo_w;

    // session register page test
    function automatic logic is_session(input logic [1:0] sec, input logic [7:0] pg);
        is_session = ((sec == SESS_SECTOR_LO) && (pg == SESS_PAGE_LO0 || pg == SESS_PAGE_LO1)) ||
                     ((sec == SESS_SECTOR_HI) && (pg == SESS_PAGE_HI0 || pg == SESS_PAGE_HI1));
    endfunction : is_session

    // page window test, used for mirror and message end
    function automatic logic in_range(input logic [7:0] pg, input logic [7:0] lo, input logic [8:0] hi);
        in_range = (pg >= lo) && ({1'b0, pg} <= hi);
    endfunction : in_range

    // two-flop synchronisers; third stage only for edge finding
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            scl_s_q   <= 3'h7;
            sda_s_q   <= 3'h7;
            field_s_q <= 2'h0;
            vcc_s_q   <= 2'h0;
        end else begin
            scl_s_q   <= {scl_s_q[1:0], scl_in};
            sda_s_q   <= {sda_s_q[1:0], sda_in};
            field_s_q <= {field_s_q[0], nfc_field_in};
            vcc_s_q   <= {vcc_s_q[0], vcc_present_in};
        end
    end

    // bus conditions seen on synchronised pins
    assign start_w    = scl_s_q[1] && scl_s_q[2] && sda_s_q[2] && !sda_s_q[1];
    assign stop_w     = scl_s_q[1] && scl_s_q[2] && !sda_s_q[2] && sda_s_q[1];
    assign scl_rise_w = scl_s_q[1] && !scl_s_q[2];

    // address phase after a start condition
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            ser_q      <= DIMA_SER_IDLE;
            bit_cnt_q  <= 4'h0;
            shift_q    <= 8'h00;
            addr_hit_q <= 1'b0;
        end else begin
            addr_hit_q <= 1'b0;
            if (start_w) begin
                ser_q     <= DIMA_SER_ADDR;
                bit_cnt_q <= 4'h0;
            end else if (stop_w) begin
                ser_q <= DIMA_SER_IDLE;
            end else begin
                case (ser_q)
                    DIMA_SER_ADDR: begin
                        if (scl_rise_w) begin
                            shift_q   <= {shift_q[6:0], sda_s_q[1]};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                            if (bit_cnt_q == 4'h7) begin
                                ser_q      <= DIMA_SER_BUSY;
                                addr_hit_q <= (shift_q[6:0] == SLAVE_ADDR);  // direction bit ignored
                            end
                        end
                    end
                    DIMA_SER_BUSY: ser_q <= DIMA_SER_BUSY;
                    default:       ser_q <= DIMA_SER_IDLE;
                endcase
            end
        end
    end

    // contactless request classification
    always_comb begin
        mir_lo_w  = 8'(mirror_base_page_in << MIRROR_SHIFT);                       // [RULE15]
        is_sess_w = is_session(nfc_sector_in, nfc_page_in);
        is_mir_w  = mirror_enable_in && !passthrough_enable_in && vcc_s_q[1] &&    // [RULE13] [RULE14] [RULE18]
                    (nfc_sector_in == MIRROR_SECTOR) &&
                    in_range(nfc_page_in, mir_lo_w, 9'({1'b0, mir_lo_w} + 9'(MIRROR_PAGES - 1)));
        mem_cmd_w = (nfc_cmd_in == DIMA_CMD_READ) || (nfc_cmd_in == DIMA_CMD_FAST_READ) ||
                    (nfc_cmd_in == DIMA_CMD_WRITE) || (nfc_cmd_in == DIMA_CMD_FAST_WRITE);
        wr_cmd_w  = (nfc_cmd_in == DIMA_CMD_WRITE) || (nfc_cmd_in == DIMA_CMD_FAST_WRITE);
    end

    // contactless grant or refusal
    always_comb begin
        grant_w    = 1'b0;
        nak_w      = 1'b0;
        lock_nfc_w = 1'b0;
        if (nfc_req_in) begin
            if (nfc_cmd_in == DIMA_CMD_HALT || nfc_cmd_in == DIMA_CMD_SECTOR_SEL) begin
                grant_w = 1'b1;                                                    // [RULE3]
            end else if (!mem_cmd_w) begin
                nak_w = 1'b1;
            end else if (is_sess_w && !wr_cmd_w) begin
                grant_w = 1'b1;                                                    // [RULE3] [RULE7]
            end else if (i2c_locked_q && !passthrough_enable_in) begin
                nak_w = 1'b1;                                                      // [RULE5] [RULE7] [RULE9]
            end else if (is_mir_w && wr_cmd_w && nfc_page_locked_ro_in) begin
                nak_w = 1'b1;                                                      // [RULE17]
            end else if (is_mir_w && wr_cmd_w && pwd_auth_enable_in && buffer_password_protect_in &&
                         (nfc_page_in >= protect_start_page_in) && !nfc_authenticated_in) begin
                nak_w = 1'b1;                                                      // [RULE16]
            end else begin
                grant_w    = 1'b1;
                lock_nfc_w = !passthrough_enable_in && field_s_q[1];               // [RULE10]
            end
        end
    end

    // end of message seen by a granted read
    assign msg_set_w = grant_w && !wr_cmd_w && mem_cmd_w && !is_sess_w &&
                       in_range(final_message_page_in, nfc_page_in,
                                (nfc_cmd_in == DIMA_CMD_FAST_READ) ? {1'b0, nfc_end_page_in}
                                                                   : 9'({1'b0, nfc_page_in} + 9'h003));

    // contactless answer registers
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            nfc_ack_out        <= 1'b0;
            nfc_nak_out        <= 1'b0;
            nfc_to_sram_out    <= 1'b0;
            nfc_to_session_out <= 1'b0;
            nfc_sram_page_out  <= 4'h0;
        end else begin
            nfc_ack_out <= grant_w;
            nfc_nak_out <= nak_w;
            if (nfc_req_in) begin
                nfc_to_sram_out    <= is_mir_w && mem_cmd_w;                       // [RULE13]
                nfc_to_session_out <= is_sess_w && mem_cmd_w;
                nfc_sram_page_out  <= 4'(nfc_page_in - mir_lo_w);                  // [RULE15]
            end
        end
    end

    // watchdog on the host lock
    assign wdt_expire_w = i2c_locked_q && (wdt_q == WDT_W'(WDT_LEN - 1));
    always_ff @(posedge clk_sys_in) begin
        if (rst_in || !i2c_locked_q || i2c_req_in || addr_hit_q) begin
            wdt_q <= '0;
        end else if (!wdt_expire_w) begin
            wdt_q <= wdt_q + WDT_W'(1);
        end
    end

    // host-side lock flag; a new address hit wins over a clear
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            i2c_locked_q <= LOCK_RESET;                                            // [RULE2]
        end else if (addr_hit_q && nfc_idle_halt_in && !contactless_lock_flag_q && !lock_nfc_w &&
                     !passthrough_enable_in) begin
            i2c_locked_q <= 1'b1;                                                  // [RULE6] [RULE19] [RULE1]
        end else if (i2c_unlock_in || wdt_expire_w) begin
            i2c_locked_q <= 1'b0;                                                  // [RULE8]
        end
    end

    // contactless lock flag; a new grant wins over completion
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            contactless_lock_flag_q <= LOCK_RESET;                                             // [RULE2]
        end else if (!field_s_q[1]) begin
            contactless_lock_flag_q <= 1'b0;                                                   // [RULE11]
        end else if (lock_nfc_w) begin
            contactless_lock_flag_q <= 1'b1;                                                   // [RULE10]
        end else if (nfc_done_in || (nfc_req_in && nfc_cmd_in == DIMA_CMD_HALT)) begin
            contactless_lock_flag_q <= 1'b0;                                                   // [RULE11]
        end
    end

    // message read done; set wins over clear
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            msg_done_q <= MSG_RESET;
        end else if (msg_set_w) begin
            msg_done_q <= 1'b1;                                                    // [RULE12]
        end else if (msg_done_clear_in) begin
            msg_done_q <= 1'b0;
        end
    end

    // host answers
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            i2c_ack_out  <= 1'b0;
            i2c_nack_out <= 1'b0;
        end else begin
            i2c_ack_out  <= i2c_req_in && (i2c_reg_cmd_in || !contactless_lock_flag_q);        // [RULE4] [RULE10]
            i2c_nack_out <= i2c_req_in && !i2c_reg_cmd_in && contactless_lock_flag_q;          // [RULE4]
        end
    end

    // status outputs
    assign i2c_locked_out        = i2c_locked_q;
    assign contactless_lock_flag_out         = contactless_lock_flag_q;
    assign message_read_done_out = msg_done_q;

    // checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    property p_one_owner;
        !(i2c_locked_q && contactless_lock_flag_q);
    endproperty
    a_one_owner: assert property (p_one_owner) else $error("both interfaces own memory"); // [RULE1]

    property p_reset_clear;
        disable iff (1'b0) rst_in |=> !i2c_locked_q && !contactless_lock_flag_q;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("locks not reset"); // [RULE2]

    property p_host_nak;
        nfc_req_in && i2c_locked_q && !passthrough_enable_in && wr_cmd_w |=> nfc_nak_out && !nfc_ack_out;
    endproperty
    a_host_nak: assert property (p_host_nak) else $error("memory write granted under host lock"); // [RULE7]

    property p_sess_read;
        nfc_req_in && is_sess_w && nfc_cmd_in == DIMA_CMD_READ |=> nfc_ack_out && nfc_to_session_out;
    endproperty
    a_sess_read: assert property (p_sess_read) else $error("session read refused"); // [RULE3]

    property p_host_refused;
        contactless_lock_flag_q && i2c_req_in && !i2c_reg_cmd_in |=> i2c_nack_out && !i2c_ack_out;
    endproperty
    a_host_refused: assert property (p_host_refused) else $error("host access under rf lock"); // [RULE10]

    property p_reg_served;
        i2c_req_in && i2c_reg_cmd_in |=> i2c_ack_out;
    endproperty
    a_reg_served: assert property (p_reg_served) else $error("register command not served"); // [RULE4]

    property p_rf_done;
        nfc_done_in && !nfc_req_in |=> !contactless_lock_flag_q;
    endproperty
    a_rf_done: assert property (p_rf_done) else $error("contactless lock not released"); // [RULE11]

    property p_wdt;
        i2c_locked_q && wdt_q == WDT_W'(WDT_LEN - 1) && !addr_hit_q |=> !i2c_locked_q;
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog missed"); // [RULE8]

    property p_mirror;
        nfc_req_in && nfc_cmd_in == DIMA_CMD_READ && mirror_enable_in && !passthrough_enable_in &&
        vcc_s_q[1] && mirror_base_page_in == 8'h01 && nfc_sector_in == 2'h0 && nfc_page_in == 8'h13
        |=> nfc_to_sram_out && nfc_sram_page_out == 4'hF;
    endproperty
    a_mirror: assert property (p_mirror) else $error("mirror window misplaced"); // [RULE15]

    property p_ro;
        nfc_req_in && is_mir_w && wr_cmd_w && nfc_page_locked_ro_in |=> nfc_nak_out;
    endproperty
    a_ro: assert property (p_ro) else $error("write to locked mirrored page"); // [RULE17]

    property p_msg;
        msg_set_w |=> message_read_done_out ##1 (message_read_done_out || $past(msg_done_clear_in));
    endproperty
    a_msg: assert property (p_msg) else $error("read-done flag not set"); // [RULE12]
endmodule : dima_arbiter

// File: verilog/dima_pkg.sv
/*
 * dima_pkg: arbiter constants.
 * Assumes a 125 MHz clock; pages are contactless page numbers.
 */
package dima_pkg;
    // system clock period and watchdog time
    localparam int CLK_PERIOD_PS = 8000;
    localparam int WDT_TIME_US   = 20;
    localparam int WDT_CYCLES    = (WDT_TIME_US * 1000000) / CLK_PERIOD_PS;

    // session register pages per sector
    localparam logic [1:0] SESS_SECTOR_LO = 2'h0;
    localparam logic [7:0] SESS_PAGE_LO0  = 8'hEC;
    localparam logic [7:0] SESS_PAGE_LO1  = 8'hED;
    localparam logic [1:0] SESS_SECTOR_HI = 2'h3;
    localparam logic [7:0] SESS_PAGE_HI0  = 8'hF8;
    localparam logic [7:0] SESS_PAGE_HI1  = 8'hF9;

    // mirror window: 64 byte buffer is 16 pages, base given in units of 4 pages
    localparam logic [1:0] MIRROR_SECTOR  = 2'h0;
    localparam int         MIRROR_PAGES   = 16;
    localparam int         MIRROR_SHIFT   = 2;

    // reset values of the session flags
    localparam logic       LOCK_RESET     = 1'b0;
    localparam logic       MSG_RESET      = 1'b0;

    // 7-bit slave address default (arbitrary)
    localparam logic [6:0] SLAVE_ADDR_DEF = 7'h55;

    // contactless commands as decoded by the front end
    typedef enum logic [2:0] {
        DIMA_CMD_READ,
        DIMA_CMD_FAST_READ,
        DIMA_CMD_WRITE,
        DIMA_CMD_FAST_WRITE,
        DIMA_CMD_SECTOR_SEL,
        DIMA_CMD_HALT,
        DIMA_CMD_OTHER
    } dima_cmd_t;
endpackage : dima_pkg

// File: verification/dima_host_model.sv
/*
 * dima_host_model: serial host sending start, address byte, stop.
 * Assumes pulled-up wires; clock rests high between frames.
 */
`timescale 1ns/10ps
module dima_host_model #(
    parameter int HALF_NS = 40
) (
    // wire levels seen by the arbiter
    output logic scl_out,
    output logic sda_out
);
    // idle bus: both lines released to the pull-up
    initial begin
        scl_out = 1'h1;
        sda_out = 1'h1;
    end

    // start, address msb first, direction bit, released ack slot, stop
    task automatic send_address(input logic [6:0] addr, input logic rd);
        logic [7:0] frame;
        frame = {addr, rd};
        sda_out = 1'h0;
        #(HALF_NS);
        for (int i = 8; i >= 0; i--) begin
            scl_out = 1'h0;
            #(HALF_NS / 2);
            sda_out = (i == 0) ? 1'h1 : frame[i - 1];  // data moves only while clock is low
            #(HALF_NS / 2);
            scl_out = 1'h1;
            #(HALF_NS);
        end
        scl_out = 1'h0;
        #(HALF_NS / 2);
        sda_out = 1'h0;
        #(HALF_NS / 2);
        scl_out = 1'h1;
        #(HALF_NS / 2);
        sda_out = 1'h1;  // stop: data rises while clock is high
    endtask : send_address
endmodule : dima_host_model

// File: verification/dima_arbiter_test.sv
/*
 * dima_arbiter_test: self-checking arbiter bench.
 * Assumes serial pins from dima_host_model; requests driven here.
 */
`timescale 1ns/10ps
module dima_arbiter_test;
    import dima_pkg::*;
    localparam int         WDT  = 64;
    localparam logic [6:0] ADDR = 7'h3B;  // arbitrary slave address
    // stimulus with time zero values
    logic       clk_sys_in = 1'h0, rst_in = 1'h1, nfc_field_in = 1'h1, vcc_present_in = 1'h1;
    logic       passthrough_enable_in = 1'h0, mirror_enable_in = 1'h0, pwd_auth_enable_in = 1'h0;
    logic       buffer_password_protect_in = 1'h0, nfc_req_in = 1'h0, nfc_idle_halt_in = 1'h0;
    logic       nfc_authenticated_in = 1'h0, nfc_page_locked_ro_in = 1'h0, nfc_done_in = 1'h0;
    logic       i2c_req_in = 1'h0, i2c_reg_cmd_in = 1'h0, i2c_reg_read_in = 1'h0;
    logic       i2c_unlock_in = 1'h0, msg_done_clear_in = 1'h0;
    logic [7:0] mirror_base_page_in = 8'h01, final_message_page_in = 8'h20, protect_start_page_in = 8'hE0;
    logic [7:0] nfc_page_in = 8'h00, nfc_end_page_in = 8'h00;
    logic [1:0] nfc_sector_in = 2'h0;
    dima_cmd_t  nfc_cmd_in = DIMA_CMD_READ;
    // observed outputs and pins
    logic       scl_in, sda_in, nfc_ack_out, nfc_nak_out, nfc_to_sram_out, nfc_to_session_out;
    logic       i2c_ack_out, i2c_nack_out, i2c_locked_out, contactless_lock_flag_out, message_read_done_out;
    logic [3:0] nfc_sram_page_out;
    int         err_count = 0, comparisons = 0, seed = 74876, r, n, b, pg;

    dima_host_model host_m (.scl_out(scl_in), .sda_out(sda_in));
    dima_arbiter #(.WDT_LEN(WDT), .SLAVE_ADDR(ADDR)) dut (
        .clk_sys_in, .rst_in, .scl_in, .sda_in, .nfc_field_in, .vcc_present_in, .passthrough_enable_in,
        .mirror_enable_in, .mirror_base_page_in, .final_message_page_in, .protect_start_page_in,
        .pwd_auth_enable_in, .buffer_password_protect_in, .nfc_req_in, .nfc_cmd_in, .nfc_sector_in,
        .nfc_page_in, .nfc_end_page_in, .nfc_idle_halt_in, .nfc_authenticated_in, .nfc_page_locked_ro_in,
        .nfc_done_in, .nfc_ack_out, .nfc_nak_out, .nfc_to_sram_out, .nfc_to_session_out, .nfc_sram_page_out,
        .i2c_req_in, .i2c_reg_cmd_in, .i2c_reg_read_in, .i2c_unlock_in, .msg_done_clear_in, .i2c_ack_out,
        .i2c_nack_out, .i2c_locked_out, .contactless_lock_flag_out, .message_read_done_out
    );

    // 125 MHz system clock
    initial begin
        forever #4 clk_sys_in = ~clk_sys_in;
    end

    // compare helpers
    task automatic chk_bit(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit
    task automatic chk_page(input string what, input logic [3:0] exp, input logic [3:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_page

    // true when a page falls inside the 16-page buffer window
    function automatic logic in_win(input int p, input int base);
        return p >= base * 4 && p < base * 4 + 16;
    endfunction : in_win

    // one contactless request, answer checked one cycle later
    task automatic nfc(input dima_cmd_t c, input logic [7:0] p, input logic exp_ack, input string what);
        @(posedge clk_sys_in);
        nfc_cmd_in      <= c;
        nfc_page_in     <= p;
        nfc_end_page_in <= p;
        nfc_req_in      <= 1'h1;
        @(posedge clk_sys_in);
        nfc_req_in <= 1'h0;
        #1;
        chk_bit({what, " ack"}, exp_ack, nfc_ack_out);
        chk_bit({what, " nak"}, !exp_ack, nfc_nak_out);
    endtask : nfc

    // one host transaction, register or memory
    task automatic host(input logic reg_cmd, input logic exp_ack, input string what);
        @(posedge clk_sys_in);
        i2c_reg_cmd_in  <= reg_cmd;
        i2c_reg_read_in <= ~i2c_reg_read_in;
        i2c_req_in      <= 1'h1;
        @(posedge clk_sys_in);
        i2c_req_in <= 1'h0;
        #1;
        chk_bit({what, " ack"}, exp_ack, i2c_ack_out);
        chk_bit({what, " nack"}, !exp_ack, i2c_nack_out);
    endtask : host

    // one-cycle pulse: 0 done, 1 host unlock, other read-done clear
    task automatic pulse(input int s);
        @(posedge clk_sys_in);
        case (s)
            0: nfc_done_in <= 1'h1;
            1: i2c_unlock_in <= 1'h1;
            default: msg_done_clear_in <= 1'h1;
        endcase
        @(posedge clk_sys_in);
        nfc_done_in       <= 1'h0;
        i2c_unlock_in     <= 1'h0;
        msg_done_clear_in <= 1'h0;
        #1;
    endtask : pulse

    // address frame, then bounded wait for lock
    task automatic addr_lock(input logic [6:0] a, input logic exp, input string what);
        int k;
        host_m.send_address(a, 1'h0);
        k = 0;
        while (i2c_locked_out !== 1'h1 && k < 40) begin
            @(posedge clk_sys_in);
            k++;
        end
        #1;
        chk_bit(what, exp, i2c_locked_out);
    endtask : addr_lock

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    // the two lock flags are never up together
    always @(posedge clk_sys_in) begin
        if (!rst_in && i2c_locked_out === 1'h1 && contactless_lock_flag_out === 1'h1) begin
            chk_bit("single owner", 1'h0, 1'h1);
        end
    end

    // hang guard
    initial begin
        #(8 * 40000);
        err_count++;
        summarize();
    end

    // directed corners, then random
    initial begin
        repeat (8) @(posedge clk_sys_in);
        rst_in <= 1'h0;
        repeat (3) @(posedge clk_sys_in);
        #1;
        chk_bit("hlock rst", 1'h0, i2c_locked_out);
        chk_bit("rlock rst", 1'h0, contactless_lock_flag_out);
        host(1'h0, 1'h1, "hmem idle");
        nfc(DIMA_CMD_READ, 8'h10, 1'h1, "rd");
        chk_bit("rlock set", 1'h1, contactless_lock_flag_out);
        host(1'h0, 1'h0, "hmem rlock");
        host(1'h1, 1'h1, "hreg rlock");
        nfc_idle_halt_in <= 1'h1;
        addr_lock(ADDR, 1'h0, "hlock rlock");
        pulse(0);
        chk_bit("rlock done", 1'h0, contactless_lock_flag_out);
        nfc(DIMA_CMD_WRITE, 8'h30, 1'h1, "wr");
        nfc(DIMA_CMD_HALT, 8'h00, 1'h1, "halt");
        chk_bit("rlock halt", 1'h0, contactless_lock_flag_out);
        nfc(DIMA_CMD_OTHER, 8'h10, 1'h0, "other");
        nfc(DIMA_CMD_READ, 8'h10, 1'h1, "rd2");
        nfc_field_in <= 1'h0;
        repeat (4) @(posedge clk_sys_in);
        #1;
        chk_bit("rlock field", 1'h0, contactless_lock_flag_out);
        nfc_field_in <= 1'h1;
        repeat (4) @(posedge clk_sys_in);
        addr_lock(7'h2A, 1'h0, "bad addr");
        addr_lock(ADDR, 1'h1, "addr");
        nfc(DIMA_CMD_READ, 8'h10, 1'h0, "rd hlock");
        nfc(DIMA_CMD_WRITE, 8'h10, 1'h0, "wr hlock");
        nfc(DIMA_CMD_READ, SESS_PAGE_LO0, 1'h1, "sess rd");
        chk_bit("sess path", 1'h1, nfc_to_session_out);
        nfc(DIMA_CMD_SECTOR_SEL, 8'h00, 1'h1, "secsel");
        pulse(1);  // host ends its sequence
        chk_bit("hlock unlock", 1'h0, i2c_locked_out);
        addr_lock(ADDR, 1'h1, "addr2");
        host(1'h0, 1'h1, "hmem hlock");
        n = 0;
        while (i2c_locked_out === 1'h1 && n < 2 * WDT) begin
            @(posedge clk_sys_in);
            #1;
            n++;
        end
        chk_bit("wdt span", 1'h1, n >= WDT - 1 && n <= WDT + 1);
        nfc_idle_halt_in <= 1'h0;
        passthrough_enable_in <= 1'h1;  // mirror stays off here
        nfc(DIMA_CMD_READ, 8'h10, 1'h1, "rd thru");
        chk_bit("rlock thru", 1'h0, contactless_lock_flag_out);
        passthrough_enable_in <= 1'h0;
        nfc(DIMA_CMD_READ, 8'h18, 1'h1, "rd short");
        pulse(0);
        chk_bit("done early", 1'h0, message_read_done_out);
        nfc(DIMA_CMD_READ, 8'h1E, 1'h1, "rd final");
        pulse(0);
        chk_bit("done", 1'h1, message_read_done_out);
        pulse(2);
        chk_bit("done clr", 1'h0, message_read_done_out);
        nfc(DIMA_CMD_FAST_READ, 8'h20, 1'h1, "frd final");
        pulse(0);
        chk_bit("done frd", 1'h1, message_read_done_out);
        pulse(2);
        mirror_enable_in <= 1'h1;
        nfc(DIMA_CMD_READ, 8'h13, 1'h1, "mir top");
        chk_page("mir page", 4'hF, nfc_sram_page_out);
        nfc(DIMA_CMD_READ, 8'h03, 1'h1, "cc");
        chk_bit("cc path", 1'h0, nfc_to_sram_out);
        pwd_auth_enable_in         <= 1'h1;
        buffer_password_protect_in <= 1'h1;
        protect_start_page_in      <= 8'h08;
        nfc(DIMA_CMD_WRITE, 8'h09, 1'h0, "prot wr");
        nfc(DIMA_CMD_WRITE, 8'h05, 1'h1, "unprot wr");
        nfc_authenticated_in <= 1'h1;
        nfc(DIMA_CMD_WRITE, 8'h09, 1'h1, "auth wr");
        pwd_auth_enable_in   <= 1'h0;
        nfc_authenticated_in <= 1'h0;
        vcc_present_in       <= 1'h0;
        repeat (4) @(posedge clk_sys_in);
        nfc(DIMA_CMD_READ, 8'h05, 1'h1, "rd novcc");
        chk_bit("novcc path", 1'h0, nfc_to_sram_out);
        vcc_present_in <= 1'h1;
        nfc(DIMA_CMD_READ, 8'h40, 1'h1, "rd prerst");
        rst_in <= 1'h1;
        repeat (2) @(posedge clk_sys_in);
        #1;
        chk_bit("rlock rst2", 1'h0, contactless_lock_flag_out);
        rst_in <= 1'h0;
        repeat (4) @(posedge clk_sys_in);
        for (int i = 0; i < 48; i++) begin
            r  = $random(seed);
            b  = 1 + r[2:0];
            pg = b * 4 - 2 + (r[12:8] % 20);
            mirror_base_page_in   <= 8'(b);
            nfc_page_locked_ro_in <= r[16];
            nfc(dima_cmd_t'({1'h0, r[21:20]}), 8'(pg), !(r[21] && r[16] && in_win(pg, b)), "mir");
            if (nfc_ack_out === 1'h1) begin
                chk_bit("mir path", in_win(pg, b), nfc_to_sram_out);
                if (in_win(pg, b)) chk_page("mir pg", 4'(pg - b * 4), nfc_sram_page_out);
            end
        end
        summarize();
    end
endmodule : dima_arbiter_test
